// ### common/conv_seq_pkg.sv
// Constants, types and behaviour list of the converter sequence controller
// Behaviour
// RL1 - Control write starts fresh sequence
// RL2 - Write aborts running sequence, clears flags
// RL3 - Eight-select bit picks four or eight
// RL4 - Repeat bit picks single or continuous
// RL5 - Single channel uses all four selects
// RL6 - Multichannel steps through group inputs
// RL7 - Four-mode group map, slots zero to three
// RL8 - Eight-mode group map, slots zero to seven
// RL9 - Multichannel ignores low select bits
// RL10 - Done flag after first sequence
// RL11 - Normal clearing: control write clears done
// RL12 - Fast clearing: first slot read clears done
// RL13 - Pointer shows next slot written
// RL14 - Per-slot flag set on result load
// RL15 - Slot flag clearing needs status read unless fast
// RL16 - Status writable only in special mode
// RL17 - Test register dead in normal mode
// RL18 - Special mode exposes approximation bits
// RL19 - Soft reset keeps power-up bit
// RL20 - Four test select bits, sixteen modes
// RL21 - Pin register reads pin levels
// RL22 - Software keeps conversion clock 500k-2M
// RL23 - Sequence done sets irq flag, irq if enabled
// RL24 - Slots left-justified, read-only, no reset
// RL25 - Continuous wraps pointer, overwrites slots
package conv_seq_pkg;
    // ************************************************************
    // Register map (word indices on the plain port)
    // ************************************************************
    localparam logic [3:0] ADDR_START_CTRL = 4'h0;
    localparam logic [3:0] ADDR_POWER_IRQ  = 4'h1;
    localparam logic [3:0] ADDR_STATUS     = 4'h2;
    localparam logic [3:0] ADDR_TEST       = 4'h3;
    localparam logic [3:0] ADDR_PINS       = 4'h4;
    localparam logic [3:0] ADDR_SLOT0      = 4'h8;

    // Start control fields
    localparam int BIT_EIGHT = 6;
    localparam int BIT_SCAN  = 5;
    localparam int BIT_MULTICHANNEL_SELECT  = 4;
    // Power/irq control fields
    localparam int BIT_PWR   = 7;
    localparam int BIT_FAST  = 6;
    localparam int BIT_IRQEN = 1;
    localparam int BIT_IRQF  = 0;
    // Status fields
    localparam int BIT_DONE  = 15;
    // Test fields
    localparam int BIT_SRST  = 14;
    localparam int BIT_TOUT  = 15;

    localparam logic [7:0] START_CTRL_RST = 8'h00;
    localparam logic [7:0] POWER_IRQ_RST  = 8'h00;
    localparam logic [9:0] SAR_RST        = 10'h000;
    localparam logic [3:0] TSEL_RST       = 4'h0;

    // Per-conversion time in clocks
    localparam int          CONV_CYCLES = 20;
    localparam logic [4:0]  CONV_LAST   = 5'(CONV_CYCLES - 1);

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } seq_state_e;
endpackage

// ### rtl/conv_seq_ctrl.sv
// Sequencer, flags and registers of the converter unit
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
module conv_seq_ctrl
    import conv_seq_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_special_mode,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_pin_levels,
    input  wire logic [9:0]  i_conv_result,
    output logic      [15:0] o_rdata,
    output logic      [3:0]  o_mux_sel,
    output logic             o_converting,
    output logic             o_irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        seq_state_e  state;
        logic [7:0]  start_ctrl;
        logic [7:0]  power_irq;
        logic        done;
        logic [7:0]  ccf;
        logic [7:0]  ccf_armed;
        logic [2:0]  ptr;
        logic [4:0]  tick;
        logic [9:0]  sar;
        logic [3:0]  tsel;
        logic [15:0] rdata;
        logic [3:0]  mux_sel;
        logic        converting;
        logic        irq;
    } ctrl_s;

    ctrl_s       ctrl_reg;
    ctrl_s       ctrl_next;
    logic [15:0] slot_mem [8];
    logic        slot_we;
    logic [2:0]  slot_idx;

    logic        eight;
    logic        scan;
    logic        multichannel_select;
    logic [3:0]  csel;
    logic [2:0]  last_ptr;
    logic [2:0]  slot_of_ptr;
    logic [3:0]  chan_now;
    logic        wr_start;
    logic        rd_slot;
    logic [2:0]  rd_idx;
    logic        conv_end;

    assign eight    = ctrl_reg.start_ctrl[BIT_EIGHT];
    assign scan     = ctrl_reg.start_ctrl[BIT_SCAN];
    assign multichannel_select     = ctrl_reg.start_ctrl[BIT_MULTICHANNEL_SELECT];
    assign csel     = ctrl_reg.start_ctrl[3:0];
    assign last_ptr = eight ? 3'h7 : 3'h3;                    // [RL3]
    assign wr_start = i_wr && (i_addr == ADDR_START_CTRL);
    assign rd_slot  = i_rd && (i_addr[3] == 1'b1);
    assign rd_idx   = i_addr[2:0];
    assign conv_end = (ctrl_reg.state == ST_RUN) && (ctrl_reg.tick == CONV_LAST);

    // ************************************************************
    // Channel and slot mapping
    // ************************************************************
    always_comb begin
        if (!multichannel_select) begin
            chan_now    = csel;                               // [RL5]
            slot_of_ptr = ctrl_reg.ptr;
        end else if (eight) begin
            chan_now    = {csel[3], ctrl_reg.ptr};            // [RL8] [RL9]
            slot_of_ptr = ctrl_reg.ptr;
        end else begin
            chan_now    = {csel[3:2], ctrl_reg.ptr[1:0]};     // [RL6] [RL7] [RL9]
            slot_of_ptr = {1'b0, ctrl_reg.ptr[1:0]};
        end
    end

    assign slot_we  = conv_end;
    assign slot_idx = slot_of_ptr;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next.rdata = 16'h0000;

        // Conversion stepping
        if (ctrl_reg.state == ST_RUN) begin
            ctrl_next.tick = ctrl_reg.tick + 5'h01;
            if (conv_end) begin
                ctrl_next.tick = 5'h00;
                ctrl_next.ccf[slot_of_ptr] = 1'b1;              // [RL14]
                ctrl_next.ccf_armed[slot_of_ptr] = 1'b0;
                if (ctrl_reg.ptr == last_ptr) begin
                    ctrl_next.ptr  = 3'h0;                      // [RL25]
                    ctrl_next.done = 1'b1;                      // [RL10]
                    ctrl_next.power_irq[BIT_IRQF] = 1'b1;       // [RL23]
                    if (!scan) begin
                        ctrl_next.state = ST_IDLE;              // [RL4]
                    end
                end else begin
                    ctrl_next.ptr = ctrl_reg.ptr + 3'h1;        // [RL13]
                end
            end
        end

        // Reads and their side effects
        if (i_rd) begin
            unique case (i_addr)
                ADDR_START_CTRL: ctrl_next.rdata = {8'h00, ctrl_reg.start_ctrl};
                ADDR_POWER_IRQ:  ctrl_next.rdata = {8'h00, ctrl_reg.power_irq};
                ADDR_STATUS: begin
                    ctrl_next.rdata = {ctrl_reg.done, 4'h0, ctrl_reg.ptr, ctrl_reg.ccf};
                    ctrl_next.ccf_armed = ctrl_reg.ccf;         // [RL15]
                end
                ADDR_TEST: begin
                    if (i_special_mode) begin                   // [RL17]
                        ctrl_next.rdata = {1'b0, 1'b0, ctrl_reg.tsel, ctrl_reg.sar}; // [RL18]
                    end
                end
                ADDR_PINS:       ctrl_next.rdata = {8'h00, i_pin_levels};           // [RL21]
                default: begin
                    if (rd_slot) begin
                        ctrl_next.rdata = slot_mem[rd_idx];     // [RL24]
                        if (ctrl_reg.power_irq[BIT_FAST] || ctrl_reg.ccf_armed[rd_idx]) begin
                            ctrl_next.ccf[rd_idx] = 1'b0;       // [RL15]
                            ctrl_next.ccf_armed[rd_idx] = 1'b0;
                        end
                        if (ctrl_reg.power_irq[BIT_FAST] && rd_idx == 3'h0) begin
                            ctrl_next.done = 1'b0;              // [RL12]
                        end
                    end
                end
            endcase
            // Hardware set wins over a read clear
            if (conv_end) begin
                ctrl_next.ccf[slot_of_ptr]       = 1'b1;
                ctrl_next.ccf_armed[slot_of_ptr] = 1'b0;
            end
            if (conv_end && ctrl_reg.ptr == last_ptr) begin
                ctrl_next.done = 1'b1;
            end
        end

        // Writes
        if (i_wr) begin
            unique case (i_addr)
                ADDR_START_CTRL: begin
                    ctrl_next.start_ctrl = i_wdata[7:0];
                    ctrl_next.done      = 1'b0;                 // [RL2] [RL11]
                    ctrl_next.ccf       = 8'h00;                // [RL2]
                    ctrl_next.ccf_armed = 8'h00;
                    ctrl_next.ptr       = 3'h0;
                    ctrl_next.tick      = 5'h00;
                    ctrl_next.state     = ctrl_reg.power_irq[BIT_PWR] ? ST_RUN : ST_IDLE; // [RL1]
                end
                ADDR_POWER_IRQ: begin
                    ctrl_next.power_irq[7:1] = i_wdata[7:1];
                    if (!i_wdata[BIT_PWR]) begin
                        ctrl_next.state = ST_IDLE;
                    end
                end
                ADDR_STATUS: begin
                    if (i_special_mode) begin                   // [RL16]
                        ctrl_next.done = i_wdata[BIT_DONE];
                        ctrl_next.ccf  = i_wdata[7:0];
                        // Hardware set still wins over the write
                        if (conv_end) begin
                            ctrl_next.ccf[slot_of_ptr] = 1'b1;
                        end
                        if (conv_end && ctrl_reg.ptr == last_ptr) begin
                            ctrl_next.done = 1'b1;
                        end
                    end
                end
                ADDR_TEST: begin
                    if (i_special_mode) begin                   // [RL17]
                        ctrl_next.sar  = i_wdata[9:0];          // [RL18]
                        ctrl_next.tsel = i_wdata[13:10];        // [RL20]
                        if (i_wdata[BIT_SRST]) begin            // [RL19]
                            ctrl_next.state      = ST_IDLE;
                            ctrl_next.start_ctrl = START_CTRL_RST;
                            ctrl_next.power_irq  = POWER_IRQ_RST | (ctrl_reg.power_irq & 8'h80);
                            ctrl_next.done       = 1'b0;
                            ctrl_next.ccf        = 8'h00;
                            ctrl_next.ccf_armed  = 8'h00;
                            ctrl_next.ptr        = 3'h0;
                            ctrl_next.tick       = 5'h00;
                            ctrl_next.sar        = SAR_RST;
                            ctrl_next.tsel       = TSEL_RST;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Sequence irq flag clears when done clears
        if (!ctrl_next.done) begin
            ctrl_next.power_irq[BIT_IRQF] = 1'b0;
        end
        if (ctrl_next.state == ST_RUN && !(ctrl_reg.state == ST_RUN) ) begin
            ctrl_next.sar = ctrl_next.sar;
        end else if (conv_end) begin
            ctrl_next.sar = i_conv_result;
        end

        ctrl_next.mux_sel    = chan_now;
        ctrl_next.converting = (ctrl_next.state == ST_RUN);
        ctrl_next.irq        = ctrl_next.power_irq[BIT_IRQF]
                               && ctrl_next.power_irq[BIT_IRQEN]; // [RL23]
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Result slots: no reset, left-justified 10-bit result
    always_ff @(posedge i_clk) begin
        if (slot_we) begin
            slot_mem[slot_idx] <= {i_conv_result, 6'h00};       // [RL24] [RL25]
        end
    end

    assign o_rdata      = ctrl_reg.rdata;
    assign o_mux_sel    = ctrl_reg.mux_sel;
    assign o_converting = ctrl_reg.converting;
    assign o_irq        = ctrl_reg.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    start_runs_a: assert property (wr_start && ctrl_reg.power_irq[BIT_PWR]
        |=> ctrl_reg.state == ST_RUN && ctrl_reg.ptr == 3'h0) // [RL1]
        else $error("start write did not begin sequence");
    start_clears_a: assert property (wr_start |=> !ctrl_reg.done) // [RL2]
        else $error("start write left done flag set");
    ccf_cleared_a: assert property (wr_start |=> ctrl_reg.ccf == 8'h00) // [RL2]
        else $error("start write left slot flags set");
    four_len_a: assert property (ctrl_reg.state == ST_RUN && !eight |-> ctrl_reg.ptr <= 3'h3) // [RL3]
        else $error("pointer beyond four in four mode");
    single_halt_a: assert property (conv_end && ctrl_reg.ptr == last_ptr && !scan && !i_wr
        |=> ctrl_reg.state == ST_IDLE) // [RL4]
        else $error("single sequence did not halt");
    scan_keep_a: assert property (conv_end && scan && !i_wr |=> ctrl_reg.state == ST_RUN) // [RL4]
        else $error("continuous sequence stopped");
    done_set_a: assert property (conv_end && ctrl_reg.ptr == last_ptr && !i_wr |=> ctrl_reg.done) // [RL10]
        else $error("done flag not set at sequence end");
    ccf_set_a: assert property (conv_end && !i_wr |=> ctrl_reg.ccf[$past(slot_of_ptr)]) // [RL14]
        else $error("slot flag not set on load");
    test_zero_a: assert property (i_rd && i_addr == ADDR_TEST && !i_special_mode
        |=> o_rdata == 16'h0000) // [RL17]
        else $error("test register readable in normal mode");
    mux_single_a: assert property (ctrl_reg.state == ST_RUN && !multichannel_select
        |=> o_mux_sel == $past(csel)) // [RL5]
        else $error("single channel not held");

    seq_done_c: cover property (conv_end && ctrl_reg.ptr == 3'h7);
    scan_wrap_c: cover property (conv_end && scan && ctrl_reg.ptr == last_ptr);
    fast_clear_c: cover property (rd_slot && ctrl_reg.power_irq[BIT_FAST] && ctrl_reg.done);
    abort_c: cover property (wr_start && ctrl_reg.state == ST_RUN);
    eight_multichannel_select_c: cover property (conv_end && multichannel_select && eight && ctrl_reg.ptr == 3'h7);

    // ************************************************************
    // Check helpers
    // ************************************************************
    // Loads since the sequence began
    logic [3:0] seq_conv_cnt;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_conv_cnt <= 4'h0;
        end else if (wr_start || ctrl_reg.state == ST_IDLE) begin
            seq_conv_cnt <= 4'h0;
        end else if (conv_end && ctrl_reg.ptr == last_ptr) begin
            seq_conv_cnt <= 4'h0;
        end else if (conv_end) begin
            seq_conv_cnt <= seq_conv_cnt + 4'h1;
        end
    end

    // Pointer and sequence
    seq_len_a: assert property (conv_end && ctrl_reg.ptr == last_ptr && !i_wr // [RL3]
        |-> seq_conv_cnt == {1'b0, last_ptr})
        else $error("sequence length differs from select bit");
    ptr_step_a: assert property (conv_end && ctrl_reg.ptr != last_ptr && !i_wr // [RL13]
        |=> ctrl_reg.ptr == $past(ctrl_reg.ptr) + 3'h1)
        else $error("pointer did not step");
    ptr_hold_a: assert property (!conv_end && !i_wr // [RL13]
        |=> $stable(ctrl_reg.ptr))
        else $error("pointer moved without a load");
    ptr_wrap_a: assert property (conv_end && ctrl_reg.ptr == last_ptr && !i_wr // [RL25]
        |=> ctrl_reg.ptr == 3'h0)
        else $error("pointer did not wrap");
    idle_stays_a: assert property (ctrl_reg.state == ST_IDLE && !i_wr // [RL4]
        |=> ctrl_reg.state == ST_IDLE)
        else $error("sequence started without a write");
    start_mode_a: assert property (wr_start // [RL1]
        |=> {8'h00, ctrl_reg.start_ctrl} == ($past(i_wdata) & 16'h00ff))
        else $error("start settings not taken");

    // Flags
    done_keep_a: assert property (ctrl_reg.done && !ctrl_reg.power_irq[BIT_FAST] && !i_wr // [RL11]
        |=> ctrl_reg.done)
        else $error("done flag cleared without a write");
    fast_done_a: assert property (i_rd && i_addr == ADDR_SLOT0 // [RL12]
        && ctrl_reg.power_irq[BIT_FAST] && !conv_end && !i_wr |=> !ctrl_reg.done)
        else $error("first slot read left done set");
    fast_ccf_a: assert property (rd_slot && ctrl_reg.power_irq[BIT_FAST] && !conv_end && !i_wr // [RL15]
        |=> !ctrl_reg.ccf[$past(rd_idx)])
        else $error("fast read left slot flag set");
    status_first_a: assert property (rd_slot && !ctrl_reg.power_irq[BIT_FAST] // [RL15]
        && ctrl_reg.ccf_armed == 8'h00 && !i_wr |=> (ctrl_reg.ccf & $past(ctrl_reg.ccf)) == $past(ctrl_reg.ccf))
        else $error("slot flag cleared without status read");
    ccf_only_load_a: assert property (!conv_end && !i_wr // [RL14]
        |=> (ctrl_reg.ccf & ~$past(ctrl_reg.ccf)) == 8'h00)
        else $error("slot flag set without a load");
    irq_set_a: assert property (conv_end && ctrl_reg.ptr == last_ptr && !i_wr // [RL23]
        |=> ctrl_reg.power_irq[BIT_IRQF])
        else $error("irq flag not set at sequence end");
    irq_out_a: assert property (conv_end && ctrl_reg.ptr == last_ptr && !i_wr // [RL23]
        && ctrl_reg.power_irq[BIT_IRQEN] |=> o_irq)
        else $error("enabled irq not raised");

    // Registers
    status_ro_a: assert property (i_wr && i_addr == ADDR_STATUS && !i_special_mode // [RL16]
        && !i_rd && !conv_end |=> $stable(ctrl_reg.ccf) && $stable(ctrl_reg.done))
        else $error("status written in normal mode");
    status_wr_a: assert property (i_wr && i_addr == ADDR_STATUS && i_special_mode // [RL16]
        && !i_rd && !conv_end |=> {8'h00, ctrl_reg.ccf} == ($past(i_wdata) & 16'h00ff))
        else $error("special status write lost");
    test_ignore_a: assert property (i_wr && i_addr == ADDR_TEST && !i_special_mode // [RL17]
        && !conv_end |=> $stable(ctrl_reg.sar) && $stable(ctrl_reg.tsel))
        else $error("test register written in normal mode");
    sar_write_a: assert property (i_wr && i_addr == ADDR_TEST && i_special_mode // [RL18]
        && !i_wdata[BIT_SRST] && !conv_end |=> {6'h00, ctrl_reg.sar} == ($past(i_wdata) & 16'h03ff))
        else $error("approximation bits not written");
    tsel_write_a: assert property (i_wr && i_addr == ADDR_TEST && i_special_mode // [RL20]
        && !i_wdata[BIT_SRST] |=> {12'h000, ctrl_reg.tsel} == (($past(i_wdata) >> 10) & 16'h000f))
        else $error("test select not written");
    soft_reset_a: assert property (i_wr && i_addr == ADDR_TEST && i_special_mode // [RL19]
        && i_wdata[BIT_SRST] |=> ctrl_reg.state == ST_IDLE && ctrl_reg.start_ctrl == START_CTRL_RST
        && ctrl_reg.power_irq == (POWER_IRQ_RST | ($past(ctrl_reg.power_irq) & 8'h80)))
        else $error("soft reset incomplete");
    pins_read_a: assert property (i_rd && i_addr == ADDR_PINS // [RL21]
        |=> o_rdata == {8'h00, $past(i_pin_levels)})
        else $error("pin levels not returned");
    slot_load_a: assert property (slot_we // [RL24]
        |=> slot_mem[$past(slot_idx)] == {$past(i_conv_result), 6'h00})
        else $error("slot not loaded left-justified");

    // Channel mapping
    mux_four_a: assert property (ctrl_reg.state == ST_RUN && multichannel_select && !eight // [RL6] [RL7]
        |=> (o_mux_sel & 4'hc) == ($past(csel) & 4'hc)
        && (o_mux_sel & 4'h3) == ({1'b0, $past(ctrl_reg.ptr)} & 4'h3))
        else $error("four-mode group channel wrong");
    mux_eight_a: assert property (ctrl_reg.state == ST_RUN && multichannel_select && eight // [RL8] [RL9]
        |=> (o_mux_sel & 4'h8) == ($past(csel) & 4'h8)
        && (o_mux_sel & 4'h7) == {1'b0, $past(ctrl_reg.ptr)})
        else $error("eight-mode group channel wrong");

endmodule // conv_seq_ctrl

// ### bench/conv_core_model.sv
// Behavioural model of the input multiplexer and converter core
`timescale 1ns/1ps
module conv_core_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_mux_sel,
    input  wire logic       i_converting,
    output logic      [9:0] o_conv_result
);
    logic [9:0] idle_reg;

    // Toggles so a stale code never looks valid
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_reg <= 10'h155;
        end else begin
            idle_reg <= ~idle_reg;
        end
    end

    // Code tied to the channel, valid at once; pace set by the sequencer's tick count
    assign o_conv_result = i_converting ? {i_mux_sel, 2'b10, ~i_mux_sel} : idle_reg;
endmodule // conv_core_model

// ### bench/tb.sv
// Self-checking bench of the converter sequence controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb;
    import conv_seq_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst_n;
    logic        i_special_mode;
    logic [3:0]  i_addr;
    logic [15:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  i_pin_levels;
    logic [9:0]  conv_result;
    logic [15:0] rdata;
    logic [3:0]  mux_sel;
    logic        converting;
    logic        irq;
    int          bad_count = 0;
    int          comparisons = 0;

    always #12.5 i_clk = ~i_clk;

    conv_seq_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_special_mode(i_special_mode),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_pin_levels(i_pin_levels), .i_conv_result(conv_result), .o_rdata(rdata),
        .o_mux_sel(mux_sel), .o_converting(converting), .o_irq(irq));
    conv_core_model core_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mux_sel(mux_sel),
        .i_converting(converting), .o_conv_result(conv_result));

    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] e,
                       input logic [15:0] m);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(n, e, rdata & m)
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge i_clk);
        #1;
        while (converting !== 1'b0 && n < 400) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        `CHK("sequence end", 1'b0, converting)
    endtask

    function automatic logic [15:0] slot(input logic [3:0] m);
        return {m, 2'b10, ~m, 6'h00};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        tally_and_finish();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        i_rst_n = 1'b0;
        i_special_mode = 1'b0;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_pin_levels = 8'h5a;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        wr(ADDR_TEST, 16'h03ff);
        rdc("test normal", ADDR_TEST, 16'h0000, 16'hffff);
        wr(ADDR_PINS, 16'hffff);
        rdc("pins", ADDR_PINS, 16'h005a, 16'hffff);
        rdc("unmapped", 4'h5, 16'h0000, 16'hffff);
        wr(ADDR_POWER_IRQ, 16'h0082);
        wr(ADDR_START_CTRL, 16'h0006);
        rdc("control", ADDR_START_CTRL, 16'h0006, 16'h00ff);
        `CHK("single channel", 4'h6, mux_sel)
        wait_idle();
        `CHK("irq", 1'b1, irq)
        rdc("four done", ADDR_STATUS, 16'h800f, 16'h80ff);
        for (int k = 0; k < 4; k++) rdc("slot", 4'(ADDR_SLOT0 + k), slot(4'h6), 16'hffff);
        rdc("flags cleared", ADDR_STATUS, 16'h8000, 16'h80ff);
        wr(ADDR_SLOT0, 16'h1234);
        rdc("slot ro", ADDR_SLOT0, slot(4'h6), 16'hffff);
        wr(ADDR_START_CTRL, 16'h005b);
        wait_idle();
        rdc("eight done", ADDR_STATUS, 16'h80ff, 16'h80ff);
        for (int k = 0; k < 8; k++) rdc("slot", 4'(ADDR_SLOT0 + k), slot(4'(8 + k)), 16'hffff);
        wr(ADDR_START_CTRL, 16'h001d);
        wait_idle();
        for (int k = 0; k < 4; k++) rdc("slot", 4'(ADDR_SLOT0 + k), slot(4'(12 + k)), 16'hffff);
        rdc("slot kept", 4'(ADDR_SLOT0 + 4), slot(4'hc), 16'hffff);
        wr(ADDR_START_CTRL, 16'h0004);
        repeat (30) @(posedge i_clk);
        rdc("pointer", ADDR_STATUS, 16'h0101, 16'h87ff);
        wr(ADDR_START_CTRL, 16'h0005);
        rdc("abort", ADDR_STATUS, 16'h0000, 16'h80ff);
        wait_idle();
        rdc("slot", 4'(ADDR_SLOT0 + 3), slot(4'h5), 16'hffff);
        wr(ADDR_START_CTRL, 16'h0014);
        wait_idle();
        rdc("group one", 4'(ADDR_SLOT0 + 2), slot(4'h6), 16'hffff);
        wr(ADDR_START_CTRL, 16'h0050);
        wait_idle();
        rdc("eight low", 4'(ADDR_SLOT0 + 7), slot(4'h7), 16'hffff);
        wr(ADDR_START_CTRL, 16'h0049);
        wait_idle();
        rdc("eight single", 4'(ADDR_SLOT0 + 6), slot(4'h9), 16'hffff);
        wr(ADDR_START_CTRL, 16'h0022);
        repeat (250) @(posedge i_clk);
        #1;
        `CHK("scan running", 1'b1, converting)
        rdc("scan done", ADDR_STATUS, 16'h8000, 16'h8000);
        rdc("scan slot", ADDR_SLOT0, slot(4'h2), 16'hffff);
        wr(ADDR_POWER_IRQ, 16'h00c2);
        wr(ADDR_START_CTRL, 16'h0003);
        wait_idle();
        `CHK("irq fast", 1'b1, irq)
        rdc("slot", ADDR_SLOT0, slot(4'h3), 16'hffff);
        rdc("fast clear", ADDR_STATUS, 16'h000e, 16'h80ff);
        `CHK("irq cleared", 1'b0, irq)
        wr(ADDR_STATUS, 16'h80aa);
        rdc("status ro", ADDR_STATUS, 16'h000e, 16'h80ff);
        i_special_mode <= 1'b1;
        wr(ADDR_STATUS, 16'h8055);
        rdc("status special", ADDR_STATUS, 16'h8055, 16'h80ff);
        wr(ADDR_TEST, 16'h3ea5);
        rdc("test special", ADDR_TEST, 16'h3ea5, 16'hffff);
        wr(ADDR_TEST, 16'h4000);
        rdc("ctrl reset", ADDR_START_CTRL, 16'h0000, 16'hffff);
        rdc("power kept", ADDR_POWER_IRQ, 16'h0080, 16'hffff);
        rdc("status reset", ADDR_STATUS, 16'h0000, 16'h80ff);
        tally_and_finish();
    end
endmodule // tb
